/* File: src/serializer_cfg_defines.svh */
// register offsets, latch fields, reset values and timing counts
`ifndef SERIALIZER_CFG_DEFINES_SVH
`define SERIALIZER_CFG_DEFINES_SVH

`define CLK_PERIOD_NS       100
`define SYNC_STAGES         2
`define LATCH_COUNT         8
`define LATCH_BASE_OFF      8'h00
`define LATCH_LAST_OFF      8'h1C
`define STATUS_OFF          8'h20
`define PIN_WRITE_OFF       8'h24
`define LATCH_INIT          4'h0
`define FLD_RATE_DOUBLE     0
`define FLD_HALF_RATE       1
`define RANGE_CODE_LOW      2'h0
`define RANGE_CODE_MID      2'h1
`define RANGE_CODE_HIGH     2'h3
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: src/serializer_cfg_pkg.sv */
// types shared by the configuration block and its channel slices
package serializer_cfg_pkg;

   typedef enum logic [2:0] {
      RANGE_LOW  = 3'h1,
      RANGE_MID  = 3'h2,
      RANGE_HIGH = 3'h4
   } pll_range_t;

   typedef enum logic [2:0] {
      WR_IDLE = 3'h1,
      WR_DO   = 3'h2,
      WR_RESP = 3'h4
   } wr_state_t;

endpackage

/* File: src/tx_clock_channel.sv */
// one channel: transmit clock synthesis, range decode, character capture
`include "serializer_cfg_defines.svh"

module tx_clock_channel
   import serializer_cfg_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // configuration
   input  wire logic             rate_double,
   input  wire logic             half_rate,
   input  wire logic [1:0]       range_code,
   // reference and parallel data
   input  wire logic             ref_in,
   input  wire logic [9:0]       data_in,
   // outputs
   output logic                  clk_out,
   output pll_range_t            range_sel,
   output logic [9:0]            char_data,
   output logic                  char_valid
);

   logic ref_d1;
   logic ref_d2;
   logic rise;
   logic fall;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_d1 <= 1'b0;
         ref_d2 <= 1'b0;
      end else begin
         ref_d1 <= ref_in;
         ref_d2 <= ref_d1;
      end
   end

   assign rise = ref_d1 & ~ref_d2;
   assign fall = ~ref_d1 & ref_d2;

   // same rate follows the reference, double rate pulses on each edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_out <= 1'b0;
      end else if (rate_double) begin
         clk_out <= ref_d1 ^ ref_d2;
      end else begin
         clk_out <= ref_d1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         range_sel <= RANGE_LOW;
      end else if (range_code == `RANGE_CODE_LOW) begin
         range_sel <= RANGE_LOW;
      end else if (range_code == `RANGE_CODE_HIGH) begin
         range_sel <= RANGE_HIGH;
      end else begin
         range_sel <= RANGE_MID;
      end
   end

   // half rate takes a character on both reference edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         char_data  <= 10'h000;
         char_valid <= 1'b0;
      end else begin
         char_valid <= rise | (half_rate & fall);
         if (rise | (half_rate & fall)) begin
            char_data <= data_in;
         end
      end
   end

   a_half_rate_edge: assert property (@(posedge clk) disable iff (rst)
      (fall && half_rate) |=> (char_valid && char_data == $past(data_in)))
      else $error("falling reference edge missed in half rate");

   a_full_rate_skip: assert property (@(posedge clk) disable iff (rst)
      (fall && !half_rate) |=> !char_valid)
      else $error("falling edge taken in full rate");

   a_double_pulse: assert property (@(posedge clk) disable iff (rst)
      (rate_double && (rise || fall)) |=> clk_out)
      else $error("double rate clock misses an edge");

endmodule

/* File: src/serializer_config_control.sv */
// configuration latches, pin and AXI4-Lite write paths, per-channel clocking
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "serializer_cfg_defines.svh"

module serializer_config_control
   import serializer_cfg_pkg::*;
#(
   parameter int NCH = 2
)(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // axi4-lite write address
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [7:0]           s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   // axi4-lite write response
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output logic [1:0]                s_axi_bresp,
   // axi4-lite read address
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   input  wire logic [7:0]           s_axi_araddr,
   // axi4-lite read data
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   // configuration pin bus
   input  wire logic                 cfg_write_strobe_n,
   input  wire logic [2:0]           cfg_addr,
   input  wire logic [3:0]           cfg_data,
   // channel side
   input  wire logic [NCH-1:0]       channel_reference_clock,
   input  wire logic [2*NCH-1:0]     rate_range_select,
   input  wire logic [10*NCH-1:0]    tx_data,
   output logic [NCH-1:0]            tx_char_clock_out,
   output logic [3*NCH-1:0]          pll_range,
   output logic [10*NCH-1:0]         tx_char_data,
   output logic [NCH-1:0]            tx_char_valid
);

   // status word fits at most five channels below the write count
   if (NCH < 1 || NCH > 5) begin : g_bad_nch
      $error("NCH must be 1 to 5");
   end

   logic [3:0]        latch [`LATCH_COUNT];
   logic [31:0]       latch_flat;
   logic              strobe_s1;
   logic              strobe_s2;
   logic              strobe_s3;
   logic [2:0]        addr_s1;
   logic [2:0]        addr_s2;
   logic [3:0]        data_s1;
   logic [3:0]        data_s2;
   logic              pin_write;
   logic [2:0]        last_pin_addr;
   logic [3:0]        last_pin_data;
   logic [7:0]        pin_write_count;
   wr_state_t         wr_state;
   logic              aw_held;
   logic              w_held;
   logic [7:0]        aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              axi_write;
   logic              wr_hit;
   logic [2:0]        wr_index;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;

   // asynchronous pins pass a two-stage synchroniser; strobe idles high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_s1 <= 1'b1;
         strobe_s2 <= 1'b1;
         strobe_s3 <= 1'b1;
         addr_s1   <= 3'h7;
         addr_s2   <= 3'h7;
         data_s1   <= 4'hF;
         data_s2   <= 4'hF;
      end else begin
         strobe_s1 <= cfg_write_strobe_n;
         strobe_s2 <= strobe_s1;
         strobe_s3 <= strobe_s2;
         addr_s1   <= cfg_addr;
         addr_s2   <= addr_s1;
         data_s1   <= cfg_data;
         data_s2   <= data_s1;
      end
   end

   // write takes effect as the strobe returns high
   assign pin_write = strobe_s2 & ~strobe_s3;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_pin_addr   <= 3'h0;
         last_pin_data   <= 4'h0;
         pin_write_count <= 8'h00;
      end else if (pin_write) begin
         last_pin_addr   <= addr_s2;
         last_pin_data   <= data_s2;
         pin_write_count <= pin_write_count + 8'h01;
      end
   end

   // axi write channels are held independently until both arrive
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_state == WR_DO) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_state == WR_DO) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & (wr_state == WR_IDLE);
         s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & (wr_state == WR_IDLE);
      end
   end

   assign wr_hit   = (aw_addr[1:0] == 2'h0) && (aw_addr <= `LATCH_LAST_OFF);
   assign wr_index = aw_addr[4:2];
   assign axi_write = (wr_state == WR_DO) && wr_hit && w_strb[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_state     <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         case (wr_state)
            WR_IDLE: begin
               if (aw_held && w_held) begin
                  wr_state <= WR_DO;
               end
            end
            WR_DO: begin
               wr_state     <= WR_RESP;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state     <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state <= WR_IDLE;
            end
         endcase
      end
   end

   // latches: reset value, then pin write over a same-cycle axi write
   generate
      for (genvar i = 0; i < `LATCH_COUNT; i++) begin : g_latch
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               latch[i] <= `LATCH_INIT;
            end else if (pin_write && addr_s2 == 3'(i)) begin
               latch[i] <= data_s2;
            end else if (axi_write && wr_index == 3'(i)) begin
               latch[i] <= w_data[3:0];
            end
         end
         assign latch_flat[4*i +: 4] = latch[i];
      end
   endgenerate

   // read path answers one cycle after the address is taken
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = `RESP_OKAY;
      if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `LATCH_LAST_OFF) begin
         next_rdata[3:0] = latch[s_axi_araddr[4:2]];
      end else if (s_axi_araddr == `STATUS_OFF) begin
         next_rdata[NCH-1:0]         = tx_char_clock_out;
         next_rdata[8 +: 3*NCH]      = pll_range;
         next_rdata[31:24]           = pin_write_count;
      end else if (s_axi_araddr == `PIN_WRITE_OFF) begin
         next_rdata[3:0] = last_pin_data;
         next_rdata[6:4] = last_pin_addr;
      end else begin
         next_rresp = `RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // one slice per channel, rate modes steered by that channel's latch, range by its select pins
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_chan
         pll_range_t range_c;
         tx_clock_channel u_chan (
            .clk         (clk),
            .rst         (rst),
            .rate_double (latch[c][`FLD_RATE_DOUBLE]),
            .half_rate   (latch[c][`FLD_HALF_RATE]),
            .range_code  (rate_range_select[2*c +: 2]),
            .ref_in      (channel_reference_clock[c]),
            .data_in     (tx_data[10*c +: 10]),
            .clk_out     (tx_char_clock_out[c]),
            .range_sel   (range_c),
            .char_data   (tx_char_data[10*c +: 10]),
            .char_valid  (tx_char_valid[c])
         );
         assign pll_range[3*c +: 3] = range_c;
      end
   endgenerate

   a_pin_capture: assert property (@(posedge clk) disable iff (rst)
      pin_write |=> latch[$past(addr_s2)] == $past(data_s2))
      else $error("pin write not stored in latch");

   a_release_edge: assert property (@(posedge clk) disable iff (rst)
      (strobe_s2 && !strobe_s3) |-> ##2 (pin_write_count == $past(pin_write_count, 2) + 8'h01))
      else $error("write not counted on strobe release");

   a_no_write_low: assert property (@(posedge clk) disable iff (rst)
      (!strobe_s2 && !strobe_s3) |=> $stable(pin_write_count))
      else $error("write taken while strobe still low");

   a_reset_latch: assert property (@(posedge clk)
      $fell(rst) |-> (latch_flat == {`LATCH_COUNT{`LATCH_INIT}} && pin_write_count == 8'h00))
      else $error("latch not at init after reset");

   a_ready_after_rst: assert property (@(posedge clk)
      $fell(rst) |-> (s_axi_arready && wr_state == WR_IDLE && !s_axi_rvalid))
      else $error("block not ready at reset release");

   a_write_resp: assert property (@(posedge clk) disable iff (rst)
      (wr_state == WR_IDLE && aw_held && w_held) |-> ##2 s_axi_bvalid)
      else $error("write response late");

   a_read_hold: assert property (@(posedge clk) disable iff (rst)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
      else $error("read data dropped before accept");

   a_range_decode: assert property (@(posedge clk) disable iff (rst)
      (rate_range_select[1:0] == `RANGE_CODE_HIGH) |=> pll_range[2:0] == RANGE_HIGH)
      else $error("high range not selected");

   // handshake order on the register bus
   a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped before accept");

   a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
      (wr_state != WR_IDLE) |-> (!s_axi_awready && !s_axi_wready))
      else $error("write accepted while busy");

   a_ready_return: assert property (@(posedge clk) disable iff (rst)
      (s_axi_bvalid && s_axi_bready) |-> ##2 (s_axi_awready && s_axi_wready))
      else $error("write channels not reopened after response");

   a_read_answer: assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
      else $error("read not answered next cycle");

   a_read_refuse: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");

   a_bad_resp: assert property (@(posedge clk) disable iff (rst)
      (wr_state == WR_DO && !wr_hit) |=> (s_axi_bresp == `RESP_SLVERR))
      else $error("unmapped write not refused");

   // latch contents and pin bus capture
   a_axi_store: assert property (@(posedge clk) disable iff (rst)
      (axi_write && !(pin_write && addr_s2 == wr_index)) |=> latch[$past(wr_index)] == $past(w_data[3:0]))
      else $error("bus write not stored in latch");

   a_strobe_skip: assert property (@(posedge clk) disable iff (rst)
      !strobe_s2 |=> ($stable(last_pin_data) && $stable(last_pin_addr)))
      else $error("pin bus sampled while strobe low");

   a_status_count: assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `STATUS_OFF) |=> s_axi_rdata[31:24] == $past(pin_write_count))
      else $error("status word shows wrong write count");

   c_pin_write:  cover property (@(posedge clk) disable iff (rst) pin_write);
   c_axi_write:  cover property (@(posedge clk) disable iff (rst) axi_write);
   c_bad_read:   cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
   c_double_clk: cover property (@(posedge clk) disable iff (rst) latch[0][`FLD_RATE_DOUBLE] && tx_char_clock_out[0]);

endmodule

/* File: bench/cfg_host_model.sv */
// host controller model: device reset and pin configuration bus
module cfg_host_model (
   // clock
   input  wire logic  clk,
   // device reset and pin bus
   output logic       rst,
   output logic       cfg_write_strobe_n,
   output logic [2:0] cfg_addr,
   output logic [3:0] cfg_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      rst = 1'b1;
      cfg_write_strobe_n = 1'b1;
      cfg_addr = 3'h7;
      cfg_data = 4'hF;
   end

   task automatic do_reset(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask

   // address and data held across the strobe, lines float high afterwards
   task automatic pin_write(input logic [2:0] a, input logic [3:0] d);
      cfg_addr <= a;
      cfg_data <= d;
      @(posedge clk);
      cfg_write_strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      cfg_write_strobe_n <= 1'b1;
      repeat (3) @(posedge clk);
      cfg_addr <= 3'h7;
      cfg_data <= 4'hF;
      repeat (4) @(posedge clk);
   endtask
endmodule

/* File: bench/serializer_config_control_test.sv */
// self-checking bench for the configuration and clocking block
`include "serializer_cfg_defines.svh"

module serializer_config_control_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk = 1'b0;
   logic        rst, strobe_n;
   logic [2:0]  caddr;
   logic [3:0]  cdata, wstrb = 4'hF;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [1:0]  ref_clk = 0, clk_out, prev_out = 0;
   logic [3:0]  range_sel = 0;
   logic [19:0] tx_data = 0, char_data, prev_tx = 0;
   logic [5:0]  pll_range;
   logic [1:0]  char_valid;
   int          bad_count = 0, n_compared = 0, rises[2] = '{0, 0}, chars[2] = '{0, 0};
   int          model[8], base[2], cbase[2], a, v;

   always #50 clk = ~clk;

   cfg_host_model i_host (.clk(clk), .rst(rst), .cfg_write_strobe_n(strobe_n), .cfg_addr(caddr), .cfg_data(cdata));

   serializer_config_control #(.NCH(2)) i_dut (
      .clk(clk), .rst(rst),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .cfg_write_strobe_n(strobe_n), .cfg_addr(caddr), .cfg_data(cdata),
      .channel_reference_clock(ref_clk), .rate_range_select(range_sel), .tx_data(tx_data),
      .tx_char_clock_out(clk_out), .pll_range(pll_range), .tx_char_data(char_data),
      .tx_char_valid(char_valid)
   );

   always @(posedge clk) begin
      tx_data <= 20'($urandom);
      prev_tx <= tx_data;
      prev_out <= clk_out;
      for (int c = 0; c < 2; c++) begin
         if (clk_out[c] === 1'b1 && prev_out[c] === 1'b0) rises[c]++;
         if (char_valid[c] === 1'b1) begin
            chars[c]++;
            check("char data", 32'(char_data[10*c +: 10]), 32'(prev_tx[10*c +: 10]));
         end
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic axi_write(input logic [7:0] ad, input logic [31:0] dat, output logic [1:0] resp);
      bit aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      awaddr <= ad;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [7:0] ad, output logic [31:0] dat, output logic [1:0] resp);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [2:0] rng(input int k);
      return (k == 0) ? 3'h1 : (k == 3) ? 3'h4 : 3'h2;
   endfunction

   task automatic check_latches(input string what);
      for (int i = 0; i < 8; i++) begin
         axi_read(8'(4 * i), d, r);
         check(what, d, 32'(model[i]));
      end
   endtask

   task automatic report_and_stop;
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'hFEA30A0A));
      model = '{default: 0};
      i_host.do_reset(10);
      check_latches("latch after reset");
      for (int k = 0; k < 4; k++) begin
         range_sel <= {2'(k), 2'(3 - k)};
         repeat (3) @(posedge clk);
         check("pll range", 32'(pll_range), 32'({rng(k), rng(3 - k)}));
         axi_read(`STATUS_OFF, d, r);
         check("status range", 32'(d[13:8]), 32'({rng(k), rng(3 - k)}));
      end
      for (int n = 0; n < 10; n++) begin
         a = $urandom_range(7);
         v = $urandom;
         wstrb <= 4'($urandom);
         @(posedge clk);
         axi_write(8'(4 * a), 32'(v), r);
         check("write resp", 32'(r), 32'h0);
         if (wstrb[0]) model[a] = v & 15;
      end
      wstrb <= 4'hF;
      axi_write(8'h28, 32'h5, r);
      check("unmapped write resp", 32'(r), 32'h2);
      axi_read(8'h30, d, r);
      check("unmapped read", {d[29:0], r}, 32'h2);
      check_latches("latch after bus writes");
      for (int n = 0; n < 4; n++) begin
         a = $urandom_range(7);
         v = $urandom_range(15);
         i_host.pin_write(3'(a), 4'(v));
         model[a] = v;
         axi_read(`PIN_WRITE_OFF, d, r);
         check("last pin write", 32'(d[6:0]), 32'(a * 16 + v));
         axi_read(`STATUS_OFF, d, r);
         check("pin write count", 32'(d[31:24]), 32'(n + 1));
      end
      check_latches("latch after pin writes");
      for (int cfg = 0; cfg < 2; cfg++) begin
         axi_write(8'h00, 32'(cfg + 1), r);
         axi_write(8'h04, 32'(2 - cfg), r);
         model[0] = cfg + 1;
         model[1] = 2 - cfg;
         base = rises;
         cbase = chars;
         for (int t = 0; t < 48; t++) begin
            @(posedge clk);
            if (t % 4 == 3) ref_clk[0] <= ~ref_clk[0];
            if (t % 6 == 5) ref_clk[1] <= ~ref_clk[1];
         end
         repeat (10) @(posedge clk);
         check("clock out ch0", 32'(rises[0] - base[0]), (cfg == 0) ? 32'd12 : 32'd6);
         check("clock out ch1", 32'(rises[1] - base[1]), (cfg == 1) ? 32'd8 : 32'd4);
         check("char pulses ch0", 32'(chars[0] - cbase[0]), (cfg == 0) ? 32'h6 : 32'hC);
         check("char pulses ch1", 32'(chars[1] - cbase[1]), (cfg == 1) ? 32'h4 : 32'h8);
      end
      i_host.do_reset(3);
      model = '{default: 0};
      check("clock out after reset", 32'(clk_out), 32'h0);
      check_latches("latch after second reset");
      axi_read(`STATUS_OFF, d, r);
      check("count after reset", 32'(d[31:24]), 32'h0);
      report_and_stop();
   end
endmodule
